// ### core/rco_consts.svh
// Register offsets, field positions, reset values and widths of the reference clock output block.
`ifndef RCO_CONSTS_SVH
`define RCO_CONSTS_SVH
`define RCO_ADDR_W 4
`define RCO_OFS_CTRL_LOW 4'h0
`define RCO_OFS_CTRL_HIGH 4'h2
`define RCO_OFS_TRIM 4'h4
`define RCO_BIT_ENABLE 15
`define RCO_BIT_IDLE_STOP 13
`define RCO_BIT_PIN_DRIVE 12
`define RCO_BIT_SLEEP_RUN 11
`define RCO_BIT_SWITCH 9
`define RCO_BIT_ACTIVE 8
`define RCO_SEL_W 4
`define RCO_DIV_W 15
`define RCO_TRIM_W 9
`define RCO_TRIM_LSB 7
`define RCO_RESET_LOW 16'h0000
`define RCO_RESET_HIGH 16'h0000
`define RCO_RESET_TRIM 16'h0000
`define RCO_SRC_SYSTEM 4'h0
`define RCO_SRC_PERIPH 4'h1
`define RCO_SRC_PRIMARY 4'h2
`define RCO_SRC_FAST_RC 4'h3
`define RCO_SRC_LP_RC 4'h4
`define RCO_SRC_SECONDARY 4'h5
`define RCO_SRC_PLL8X 4'h6
`define RCO_SRC_REF_IN 4'h8
`define RCO_NUM_PINCLK 6
`endif

// ### core/rco_pkg.sv
// Types of the reference clock output block.
package rco_pkg;
  typedef enum logic [2:0] {
    RCO_OFF = 3'b001,
    RCO_RUN = 3'b010,
    RCO_DRAIN = 3'b100
  } rco_state_e;
endpackage

// ### core/rco_refclk.sv
// Reference clock output generator with register port, source select and fractional divider.
//
// Overview of operation
// R1 - Module enable bit 15 of the low control register turns the generator on and off.
// R2 - Pin drive enable bit 12 drives the generated clock onto the output pin.
// R3 - Integer divider is a 15-bit field of the high control register.
// R4 - Divider zero passes the base clock; otherwise period is 2 times divider plus trim.
// R5 - Four-bit source select picks the base clock; reserved codes give no clock.
// R6 - Request status bit 8 reads one while the clock request is active.
// R7 - Software avoids writing the low register while the request status reads one.
// R8 - Source changes only after enable cleared and hardware cleared the request status.
// R9 - Software writes divider and trim, sets switch bit, waits for its clearing.
// R10 - Hardware applies new divider and trim, then clears the switch bit.
// R11 - Trim adds a fractional part to the integer divisor.
// R12 - Idle stop bit 13 halts the generator while the device is idle.
// R13 - Sleep run bit 11 keeps the output alive in sleep; otherwise it stops.
// R14 - For sleep output software picks a base clock other than system or peripheral.
// R15 - Software enables a gated base clock source before selecting it.
// R16 - Bits 14, 10 and 7 to 4 of the low register read as zero.
// R17 - Output enable, source and divider change only at an output period boundary.
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "rco_consts.svh"
module rco_refclk
  import rco_pkg::*;
#(
  parameter int DIV_W = `RCO_DIV_W,
  parameter int TRIM_W = `RCO_TRIM_W
) (
  input wire logic CLOCK, // System clock, 40 MHz.
  input wire logic RESETN, // Asynchronous reset, active low.
  input wire logic [`RCO_ADDR_W-1:0] ADDR, // Register address.
  input wire logic [15:0] WR_DATA, // Register write data.
  input wire logic WR_STROBE, // One-cycle write strobe.
  input wire logic RD_STROBE, // One-cycle read strobe.
  output logic [15:0] RD_DATA, // Read data, valid the cycle after the read strobe.
  input wire logic IDLE_MODE, // Device is in Idle mode.
  input wire logic SLEEP_MODE, // Device is in Sleep mode.
  input wire logic PRIMARY_OSC, // Primary oscillator clock.
  input wire logic FAST_RC_OSCILLATOR, // Fast RC oscillator clock.
  input wire logic LOW_POWER_RC_OSCILLATOR, // Low-power RC oscillator clock.
  input wire logic SECONDARY_OSCILLATOR, // Secondary oscillator clock.
  input wire logic PLL8X_CLK, // 8x PLL clock.
  input wire logic REFERENCE_INPUT_PIN, // Reference clock input pin.
  output logic REFERENCE_OUTPUT_PIN, // Reference clock output level.
  output logic REFERENCE_OUTPUT_OE_N // Output enable of the pin, low while driven.
);

  logic en_r;
  logic idle_stop_r;
  logic pin_en_r;
  logic sleep_run_r;
  logic sw_r;
  logic [`RCO_SEL_W-1:0] sel_r;
  logic [DIV_W-1:0] div_r;
  logic [TRIM_W-1:0] trim_r;
  logic [`RCO_SEL_W-1:0] sel_act_r;
  logic [DIV_W-1:0] div_act_r;
  logic [TRIM_W-1:0] trim_act_r;
  logic pin_act_r;
  rco_state_e state_r;
  logic active;
  logic wr_low;
  logic [`RCO_NUM_PINCLK-1:0] pin_clk;
  logic [`RCO_NUM_PINCLK-1:0] s1_r;
  logic [`RCO_NUM_PINCLK-1:0] s2_r;
  logic [`RCO_NUM_PINCLK-1:0] s3_r;
  logic [`RCO_NUM_PINCLK-1:0] lvl_r;
  logic [`RCO_NUM_PINCLK-1:0] rise_r;
  logic sys_ph_r;
  logic per_ph_r;
  logic sel_lvl;
  logic sel_tick;
  logic run;
  logic [DIV_W-1:0] cnt_r;
  logic [TRIM_W-1:0] acc_r;
  logic carry_r;
  logic out_r;
  logic half_end;
  logic boundary;
  logic [DIV_W:0] half_len;
  logic [TRIM_W:0] acc_sum;

  assign wr_low = WR_STROBE && (ADDR == `RCO_OFS_CTRL_LOW);
  assign active = (state_r != RCO_OFF);
  assign pin_clk = {REFERENCE_INPUT_PIN, PLL8X_CLK, SECONDARY_OSCILLATOR,
                    LOW_POWER_RC_OSCILLATOR, FAST_RC_OSCILLATOR, PRIMARY_OSC};

  // Control register fields written by software.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      en_r <= 1'b0;
      idle_stop_r <= 1'b0;
      pin_en_r <= 1'b0;
      sleep_run_r <= 1'b0;
      sel_r <= '0;
      div_r <= '0;
      trim_r <= '0;
    end else if (WR_STROBE) begin
      if (ADDR == `RCO_OFS_CTRL_LOW) begin
        en_r <= WR_DATA[`RCO_BIT_ENABLE]; // R1
        idle_stop_r <= WR_DATA[`RCO_BIT_IDLE_STOP];
        pin_en_r <= WR_DATA[`RCO_BIT_PIN_DRIVE];
        sleep_run_r <= WR_DATA[`RCO_BIT_SLEEP_RUN];
        sel_r <= WR_DATA[`RCO_SEL_W-1:0];
      end
      if (ADDR == `RCO_OFS_CTRL_HIGH) begin
        div_r <= WR_DATA[DIV_W-1:0]; // R3
      end
      if (ADDR == `RCO_OFS_TRIM) begin
        trim_r <= WR_DATA[`RCO_TRIM_LSB +: TRIM_W];
      end
    end
  end

  // Switch request: a software set wins over the hardware clear in the same cycle.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sw_r <= 1'b0;
    end else if (wr_low && WR_DATA[`RCO_BIT_SWITCH]) begin
      sw_r <= 1'b1;
    end else if (sw_r && (boundary || !active)) begin
      sw_r <= 1'b0; // R10
    end
  end

  // Working copies of divider and trim, taken at a period boundary or while the request is off.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      div_act_r <= '0;
      trim_act_r <= '0;
    end else if (sw_r && (boundary || !active)) begin
      div_act_r <= div_r; // R10 R17
      trim_act_r <= trim_r;
    end
  end

  // Source changes only while the request is inactive.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sel_act_r <= '0;
    end else if (state_r == RCO_OFF) begin
      sel_act_r <= sel_r; // R8
    end
  end

  // Pin drive enable follows the register only while the output is low.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      pin_act_r <= 1'b0;
    end else if (!out_r) begin
      pin_act_r <= pin_en_r; // R2 R17
    end
  end

  // Request state: on at enable, off once the output is low after enable clears.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= RCO_OFF;
    end else begin
      unique case (state_r)
        RCO_OFF: begin
          if (en_r) begin
            state_r <= RCO_RUN; // R1 R6
          end
        end
        RCO_RUN: begin
          if (!en_r) begin
            state_r <= RCO_DRAIN;
          end
        end
        RCO_DRAIN: begin
          if (en_r) begin
            state_r <= RCO_RUN;
          end else if (!out_r) begin
            state_r <= RCO_OFF; // R6 R8
          end
        end
      endcase
    end
  end

  // Pin clocks pass three flops; a level counts once the last two agree.
  genvar gi;
  generate
    for (gi = 0; gi < `RCO_NUM_PINCLK; gi++) begin : g_sync
      always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
          rise_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_clk[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            lvl_r[gi] <= s3_r[gi];
          end
          rise_r[gi] <= (s2_r[gi] == s3_r[gi]) && s3_r[gi] && !lvl_r[gi];
        end
      end
    end
  endgenerate

  // System clock phase and peripheral clock at half the system rate.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      sys_ph_r <= 1'b0;
      per_ph_r <= 1'b0;
    end else begin
      sys_ph_r <= !sys_ph_r;
      if (sys_ph_r) begin
        per_ph_r <= !per_ph_r;
      end
    end
  end

  // Base clock selection; reserved codes give no clock.
  always_comb begin
    sel_lvl = 1'b0;
    sel_tick = 1'b0;
    case (sel_act_r) // R5
      `RCO_SRC_SYSTEM: begin
        sel_lvl = sys_ph_r;
        sel_tick = 1'b1;
      end
      `RCO_SRC_PERIPH: begin
        sel_lvl = per_ph_r;
        sel_tick = sys_ph_r;
      end
      `RCO_SRC_PRIMARY: begin
        sel_lvl = lvl_r[0];
        sel_tick = rise_r[0];
      end
      `RCO_SRC_FAST_RC: begin
        sel_lvl = lvl_r[1];
        sel_tick = rise_r[1];
      end
      `RCO_SRC_LP_RC: begin
        sel_lvl = lvl_r[2];
        sel_tick = rise_r[2];
      end
      `RCO_SRC_SECONDARY: begin
        sel_lvl = lvl_r[3];
        sel_tick = rise_r[3];
      end
      `RCO_SRC_PLL8X: begin
        sel_lvl = lvl_r[4];
        sel_tick = rise_r[4];
      end
      `RCO_SRC_REF_IN: begin
        sel_lvl = lvl_r[5];
        sel_tick = rise_r[5];
      end
      default: begin
        sel_lvl = 1'b0;
        sel_tick = 1'b0;
      end
    endcase
  end

  // The generator halts in Idle when asked to and in Sleep unless told to run.
  assign run = (state_r == RCO_RUN) && !(IDLE_MODE && idle_stop_r) && !(SLEEP_MODE && !sleep_run_r); // R12 R13
  assign half_len = {1'b0, div_act_r} + {{DIV_W{1'b0}}, carry_r};
  assign half_end = sel_tick && ({1'b0, cnt_r} + 1'b1 >= half_len);
  assign boundary = half_end && out_r;
  assign acc_sum = {1'b0, acc_r} + {1'b0, trim_act_r};

  // Divider: each half period lasts the divider plus one when the trim carries.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r <= '0;
      acc_r <= '0;
      carry_r <= 1'b0;
      out_r <= 1'b0;
    end else if (div_act_r == '0) begin
      cnt_r <= '0;
      acc_r <= '0;
      carry_r <= 1'b0;
      if (run || out_r) begin
        out_r <= run ? sel_lvl : 1'b0; // R4
      end
    end else if (!run && !out_r) begin
      cnt_r <= '0;
    end else if (sel_tick) begin
      if (half_end) begin
        cnt_r <= '0;
        out_r <= !out_r; // R4
        acc_r <= acc_sum[TRIM_W-1:0]; // R11
        carry_r <= acc_sum[TRIM_W];
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // Pin outputs.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      REFERENCE_OUTPUT_PIN <= 1'b0;
      REFERENCE_OUTPUT_OE_N <= 1'b1;
    end else begin
      REFERENCE_OUTPUT_PIN <= out_r && pin_act_r; // R2
      REFERENCE_OUTPUT_OE_N <= !pin_act_r;
    end
  end

  // Register read port; unimplemented bits and unmapped addresses read zero.
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= '0;
    end else if (RD_STROBE) begin
      case (ADDR)
        `RCO_OFS_CTRL_LOW: RD_DATA <= {en_r, 1'b0, idle_stop_r, pin_en_r, sleep_run_r, 1'b0,
                                       sw_r, active, 4'h0, sel_r}; // R6 R16
        `RCO_OFS_CTRL_HIGH: RD_DATA <= {1'b0, div_r};
        `RCO_OFS_TRIM: RD_DATA <= {trim_r, 7'h00};
        default: RD_DATA <= '0;
      endcase
    end else begin
      RD_DATA <= '0;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  sequence turn_off_s;
    (state_r == RCO_RUN) && !en_r ##1 (state_r == RCO_DRAIN);
  endsequence

  enable_start_a: assert property (en_r && state_r == RCO_OFF |=> active) // R1
    else $error("enable did not raise the request");
  pin_drive_a: assert property (pin_act_r |=> !REFERENCE_OUTPUT_OE_N && REFERENCE_OUTPUT_PIN == $past(out_r)) // R2
    else $error("pin not driven with the clock");
  divider_span_a: assert property (div_act_r != '0 |-> cnt_r <= div_act_r) // R3 R11
    else $error("half period counter overran");
  pass_through_a: assert property (div_act_r == '0 && run |=> out_r == $past(sel_lvl)) // R4
    else $error("undivided clock not passed");
  request_off_a: assert property (turn_off_s ##0 (!out_r && !en_r) |=> !active) // R6 R8
    else $error("request status not cleared after turn-off");
  source_hold_a: assert property (active |=> $stable(sel_act_r)) // R8 R5
    else $error("source changed while request active");
  switch_done_a: assert property (sw_r && boundary && !(wr_low && WR_DATA[`RCO_BIT_SWITCH])
                                  |=> !sw_r && div_act_r == $past(div_r)) // R10
    else $error("divider switch not completed");
  idle_halt_a: assert property (IDLE_MODE && idle_stop_r && !out_r |=> !out_r) // R12
    else $error("generator ran in idle");
  sleep_halt_a: assert property (SLEEP_MODE && !sleep_run_r && !out_r |=> !out_r) // R13
    else $error("generator ran in sleep");
  read_zero_a: assert property (RD_STROBE && ADDR == `RCO_OFS_CTRL_LOW
                                |=> RD_DATA[14] == 1'b0 && RD_DATA[10] == 1'b0 && RD_DATA[7:4] == 4'h0) // R16
    else $error("unimplemented bits read nonzero");
  pin_boundary_a: assert property (out_r |=> $stable(pin_act_r)) // R17
    else $error("pin enable changed mid period");

endmodule

// ### verification/rco_ext_device.sv
// Model of an external device clocked from the reference output pin.
`timescale 1ns/10ps
module rco_ext_device (
  input wire logic pin, // Output level from the block.
  input wire logic oe_n, // Pin output enable, low while driven.
  output int edges, // Rising edges seen on the wire.
  output realtime span // Time of the last four periods.
);
  realtime stamp[$];
  // A pull-down holds the wire low once the block releases it.
  wire logic lvl = oe_n ? 1'b0 : pin;
  // Both outputs are two-state and start at zero, so this process is their only driver.
  always @(posedge lvl) begin
    stamp.push_back($realtime);
    if (stamp.size() > 5) begin
      void'(stamp.pop_front());
    end
    if (stamp.size() == 5) begin
      span = stamp[4] - stamp[0];
    end
    edges++;
  end
endmodule

// ### verification/test_reference_clock_output.sv
// Self-checking bench of the reference clock output block.
`timescale 1ns/10ps
`include "rco_consts.svh"
module test_reference_clock_output import rco_pkg::*;;
  localparam logic [3:0] LO = `RCO_OFS_CTRL_LOW;
  localparam logic [3:0] OFS[4] = '{`RCO_OFS_CTRL_LOW, `RCO_OFS_CTRL_HIGH, `RCO_OFS_TRIM, 4'h6};
  localparam real HP[6] = '{155.0, 135.0, 195.0, 225.0, 115.0, 175.0};
  localparam int CODES[8] = '{1, 2, 3, 4, 5, 6, 7, 8};
  localparam logic [15:0] M_CTL[4] = '{16'hb003, 16'h9003, 16'h9003, 16'h9803};
  localparam bit M_IDLE[4] = '{1, 1, 0, 0};
  localparam bit M_RUN[4] = '{0, 1, 0, 1};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic [5:0] src = 6'h00;
  logic [15:0] rdata;
  logic pin;
  logic oe_n;
  logic [31:0] seed = 32'h9eb1;
  int err_count = 0;
  int n_compared = 0;
  int edges;
  realtime span;
  always #12.5 clk = ~clk;
  // Free-running base clocks, each slower than a quarter of the system clock.
  for (genvar g = 0; g < 6; g++) begin : g_src
    always #(HP[g]) src[g] = ~src[g];
  end
  rco_refclk dut (.CLOCK(clk), .RESETN(rst_n), .ADDR(addr), .WR_DATA(wdata), .WR_STROBE(wr),
    .RD_STROBE(rd), .RD_DATA(rdata), .IDLE_MODE(idle), .SLEEP_MODE(sleep), .PRIMARY_OSC(src[0]),
    .FAST_RC_OSCILLATOR(src[1]), .LOW_POWER_RC_OSCILLATOR(src[2]), .SECONDARY_OSCILLATOR(src[3]),
    .PLL8X_CLK(src[4]), .REFERENCE_INPUT_PIN(src[5]), .REFERENCE_OUTPUT_PIN(pin),
    .REFERENCE_OUTPUT_OE_N(oe_n));
  rco_ext_device ext (.pin(pin), .oe_n(oe_n), .edges(edges), .span(span));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic real per_ns(int code);
    return (code == 1) ? 50.0 : 2.0 * HP[(code == 8) ? 5 : code - 2];
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic poll(int b, logic v);
    logic [15:0] d;
    for (int i = 0; i < 500; i++) begin
      rd_reg(LO, d);
      if (d[b] === v) break;
    end
    chk("status bit", v, d[b]);
  endtask
  task automatic divset(int div, int trim, logic [15:0] ctl);
    logic [15:0] d;
    poll(`RCO_BIT_SWITCH, 1'b0);
    wr_reg(`RCO_OFS_CTRL_HIGH, div[15:0]);
    wr_reg(`RCO_OFS_TRIM, trim[8:0] << 7);
    wr_reg(LO, ctl | 16'h0200);
    poll(`RCO_BIT_SWITCH, 1'b0);
    rd_reg(`RCO_OFS_CTRL_HIGH, d);
    chk("divider", div[15:0], d);
  endtask
  task automatic start(logic [15:0] ctl, int div, int trim);
    logic [15:0] d;
    // The old source stays selected until the request has dropped.
    rd_reg(LO, d);
    wr_reg(LO, d & 16'h7cff);
    poll(`RCO_BIT_ACTIVE, 1'b0);
    divset(div, trim, ctl & 16'h7fff);
    wr_reg(LO, ctl);
    poll(`RCO_BIT_ACTIVE, 1'b1);
  endtask
  task automatic measure(string what, real exp, real tol);
    int e0;
    e0 = edges;
    for (int i = 0; i < 2000 && edges < e0 + 6; i++) @(posedge clk);
    n_compared++;
    if (edges < e0 + 6 || span < exp - tol || span > exp + tol) begin
      err_count++;
      $display("wrong value %s expected %0.1f seen %0.1f", what, exp, span);
    end
  endtask
  task automatic quiet(string what);
    int e0;
    repeat (50) @(posedge clk);
    e0 = edges;
    repeat (200) @(posedge clk);
    chk(what, e0, edges);
  endtask
  task automatic endt(string s);
    $display("test %s done", s);
  endtask
  initial begin
    #2000000;
    err_count++;
    stop_test();
  end
  initial begin
    logic [15:0] d;
    int div;
    int trim;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (OFS[i]) begin
      rd_reg(OFS[i], d);
      chk("reset value", 16'h0000, d);
    end
    chk("oe_n at reset", 1, oe_n);
    wr_reg(LO, 16'h75ff);
    rd_reg(LO, d);
    chk("low fields", 16'h300f, d);
    wr_reg(`RCO_OFS_CTRL_HIGH, 16'hffff);
    wr_reg(`RCO_OFS_TRIM, 16'hffff);
    rd_reg(`RCO_OFS_CTRL_HIGH, d);
    chk("divider width", 16'h7fff, d);
    rd_reg(`RCO_OFS_TRIM, d);
    chk("trim field", 16'hff80, d);
    endt("registers");
    start(16'h9000, 0, 0);
    measure("undivided", 200.0, 1.0);
    chk("oe_n driven", 0, oe_n);
    for (int i = 0; i < 6; i++) begin
      div = 1 + rnd() % 8;
      trim = (rnd() % 4) * 128;
      divset(div, trim, 16'h9000);
      measure("divided", (8 * div + trim / 64) * 25.0, 1.0);
    end
    endt("divider");
    wr_reg(LO, 16'h8000);
    quiet("pin released");
    chk("oe_n released", 1, oe_n);
    chk("pin low", 0, pin);
    wr_reg(LO, 16'h1000);
    poll(`RCO_BIT_ACTIVE, 1'b0);
    quiet("disabled");
    endt("pin and enable");
    foreach (CODES[i]) begin
      start(16'h9000 | 16'(CODES[i]), 1, 0);
      if (CODES[i] == 7) begin
        quiet("reserved source");
      end else begin
        measure("source period", 8.0 * per_ns(CODES[i]), 30.0);
      end
    end
    endt("sources");
    foreach (M_CTL[i]) begin
      start(M_CTL[i], 1, 0);
      @(posedge clk);
      idle <= M_IDLE[i];
      sleep <= !M_IDLE[i];
      if (M_RUN[i]) begin
        measure("mode running", 8.0 * per_ns(3), 30.0);
      end else begin
        quiet("mode stopped");
      end
      @(posedge clk);
      idle <= 1'b0;
      sleep <= 1'b0;
    end
    endt("idle and sleep");
    stop_test();
  end
endmodule
